// >>> card_power_seq.sv
/*
  Host-side sequencer driving the three control-code pins of a card power switch.
  Assumes card events arrive as synchronous level/strobe inputs from host software.
*/
// Function
// RULE_01: Device keeps switches off and ignores code while low input is under lockout.
// RULE_02: Device decodes 000, 001, 010, 011 to their documented output conditions.
// RULE_03: Device decodes 100, 101, 110, 111 to their documented output conditions.
// RULE_04: Host picks mode from host type and card type pairing.
// RULE_05: Multi host accepting single card switches to single sequencing, else never powers.
// RULE_06: Single host holds 000 after power-up until info request or removal.
// RULE_07: Granted info request moves to 001 and stays; refusal stays at 000.
// RULE_08: Single host returns to 000 upon removal, optionally via 110.
// RULE_09: Multi host powers up to 010, optionally via 111.
// RULE_10: Multi host holds 010 with no card until insertion.
// RULE_11: Multi host drives 011 when detecting a multi capable card.
// RULE_12: Multi card identified: move to 100, hold until removal.
// RULE_13: Single card with channel one: repower in single mode until removal.
// RULE_14: Unsupported card stays unpowered with no state change until removal.
// RULE_15: Multi host passes 111 upon removal, then returns to 010.
// RULE_16: Host drives the three control bits as device inputs.
// RULE_17: Device flags over-current after 8 ms, over-temperature at once; the model flags over-current after OC_CYCLES (20) mclk cycles.
// RULE_18: Discharge codes 110 and 111 are held for a dwell time.
`timescale 1ns/1ps
`include "card_power_defs.svh"

module card_power_seq (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Host configuration
  input  wire logic multi_host,
  input  wire logic discharge_en,
  input  wire logic accept_single,
  input  wire logic grant_5v,
  // Card events
  input  wire logic card_present,
  input  wire logic card_multi_detect,
  input  wire logic id_done,
  input  wire logic id_is_multi,
  input  wire logic channel_one_support,
  input  wire logic card_info_request,
  // Device status
  input  wire logic fault_n,
  // Control pins to the switch
  output logic      ctrl_sel_bit0,
  output logic      ctrl_sel_bit1,
  output logic      ctrl_sel_bit2,
  // Status
  output logic      single_mode,
  output logic      card_fault
);

  card_power_pkg::seq_state_e   state_r;
  card_power_pkg::seq_state_e   state_nxt;
  logic [`DWELL_W-1:0]          dwell_r;
  logic [`DWELL_W-1:0]          dwell_nxt;
  logic [2:0]                   code_nxt;
  logic                         single_nxt;

  wire logic removal = ~card_present;
  wire logic dwell_done = (dwell_r == `DWELL_W'(`DWELL_CYCLES - 1));
  wire logic in_dwell = (state_r == card_power_pkg::ST_S_DISCHG) ||
                        (state_r == card_power_pkg::ST_M_PWRUP_GND) ||
                        (state_r == card_power_pkg::ST_M_DISCHG);
  wire logic single_ok = ~id_is_multi & channel_one_support & accept_single;

  function automatic logic [2:0] code_of(input card_power_pkg::seq_state_e s);
    unique case (s)
      card_power_pkg::ST_IDLE:        code_of = `CODE_ALL_HIZ;
      card_power_pkg::ST_S_BASE:      code_of = `CODE_ALL_3V3;
      card_power_pkg::ST_S_AUX5:      code_of = `CODE_AUX_5V;
      card_power_pkg::ST_S_DISCHG:    code_of = `CODE_AUX_DISCHG;
      card_power_pkg::ST_M_PWRUP_GND: code_of = `CODE_ALL_GND;
      card_power_pkg::ST_M_EMPTY:     code_of = `CODE_ALL_HIZ;
      card_power_pkg::ST_M_DETECT:    code_of = `CODE_MULTI_DETECT; // see RULE_11
      card_power_pkg::ST_M_POWERED:   code_of = `CODE_MULTI_PWR;
      card_power_pkg::ST_M_REFUSED:   code_of = `CODE_ALL_HIZ;
      card_power_pkg::ST_M_DISCHG:    code_of = `CODE_ALL_GND;
    endcase
  endfunction

  always_comb begin
    state_nxt = state_r;
    single_nxt = single_mode;
    unique case (state_r)
      card_power_pkg::ST_IDLE: begin
        single_nxt = ~multi_host; // see RULE_04
        if (!multi_host)
          state_nxt = card_power_pkg::ST_S_BASE; // see RULE_06
        else if (discharge_en)
          state_nxt = card_power_pkg::ST_M_PWRUP_GND; // see RULE_09
        else
          state_nxt = card_power_pkg::ST_M_EMPTY; // see RULE_09
      end
      card_power_pkg::ST_S_BASE: begin
        // Refused request simply stays here
        if (card_present && card_info_request && grant_5v)
          state_nxt = card_power_pkg::ST_S_AUX5; // see RULE_07
      end
      card_power_pkg::ST_S_AUX5: begin
        if (removal)
          state_nxt = discharge_en ? card_power_pkg::ST_S_DISCHG
                                   : card_power_pkg::ST_S_BASE; // see RULE_08
      end
      card_power_pkg::ST_S_DISCHG: begin
        if (dwell_done)
          state_nxt = multi_host ? card_power_pkg::ST_M_DISCHG
                                 : card_power_pkg::ST_S_BASE; // see RULE_18
      end
      card_power_pkg::ST_M_PWRUP_GND: begin
        if (dwell_done)
          state_nxt = card_power_pkg::ST_M_EMPTY; // see RULE_18
      end
      card_power_pkg::ST_M_EMPTY: begin
        single_nxt = 1'b0;
        if (card_present && card_multi_detect)
          state_nxt = card_power_pkg::ST_M_DETECT; // see RULE_10
      end
      card_power_pkg::ST_M_DETECT: begin
        if (removal)
          state_nxt = card_power_pkg::ST_M_DISCHG; // see RULE_15
        else if (id_done && id_is_multi)
          state_nxt = card_power_pkg::ST_M_POWERED; // see RULE_12
        else if (id_done && single_ok) begin
          state_nxt = card_power_pkg::ST_S_BASE; // see RULE_13
          single_nxt = 1'b1; // see RULE_05
        end else if (id_done)
          state_nxt = card_power_pkg::ST_M_REFUSED; // see RULE_14
      end
      card_power_pkg::ST_M_POWERED, card_power_pkg::ST_M_REFUSED: begin
        if (removal)
          state_nxt = card_power_pkg::ST_M_DISCHG; // see RULE_15
      end
      card_power_pkg::ST_M_DISCHG: begin
        if (dwell_done)
          state_nxt = card_power_pkg::ST_M_EMPTY; // see RULE_15
      end
    endcase
    // Multi host in single mode leaves via discharge upon removal
    if (multi_host && single_mode && removal &&
        (state_r == card_power_pkg::ST_S_BASE || state_r == card_power_pkg::ST_S_AUX5))
      state_nxt = card_power_pkg::ST_M_DISCHG; // see RULE_05
    dwell_nxt = (in_dwell && state_nxt == state_r) ? dwell_r + `DWELL_W'(1) : '0;
    code_nxt = code_of(state_nxt);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= card_power_pkg::ST_IDLE;
      dwell_r <= '0;
      single_mode <= 1'b0;
      {ctrl_sel_bit2, ctrl_sel_bit1, ctrl_sel_bit0} <= `CODE_ALL_HIZ;
      card_fault <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dwell_r <= dwell_nxt;
      single_mode <= single_nxt;
      {ctrl_sel_bit2, ctrl_sel_bit1, ctrl_sel_bit0} <= code_nxt; // see RULE_16
      card_fault <= ~fault_n; // see RULE_17
    end
  end

  wire logic [2:0] code_out = {ctrl_sel_bit2, ctrl_sel_bit1, ctrl_sel_bit0};

  a_aux5_sticky: assert property (@(posedge mclk) disable iff (rst) // see RULE_07
    (state_r == card_power_pkg::ST_S_AUX5 && card_present) |=> state_r == card_power_pkg::ST_S_AUX5)
    else $error("aux 5V state left without removal");
  a_refuse_holds: assert property (@(posedge mclk) disable iff (rst) // see RULE_07
    (state_r == card_power_pkg::ST_S_BASE && card_info_request && !grant_5v && !multi_host)
    |=> state_r == card_power_pkg::ST_S_BASE)
    else $error("refused request changed state");
  a_s_removal: assert property (@(posedge mclk) disable iff (rst) // see RULE_08
    (state_r == card_power_pkg::ST_S_AUX5 && removal && !multi_host && !discharge_en)
    |=> code_out == `CODE_ALL_3V3)
    else $error("single removal did not return to 000");
  a_m_pwrup: assert property (@(posedge mclk) disable iff (rst) // see RULE_09
    (state_r == card_power_pkg::ST_IDLE && multi_host && !discharge_en) |=> code_out == `CODE_ALL_HIZ)
    else $error("multi power-up not 010");
  a_empty_hold: assert property (@(posedge mclk) disable iff (rst) // see RULE_10
    (state_r == card_power_pkg::ST_M_EMPTY && !card_present) |=> code_out == `CODE_ALL_HIZ)
    else $error("empty slot code not 010");
  a_detect_code: assert property (@(posedge mclk) disable iff (rst) // see RULE_11
    (state_r == card_power_pkg::ST_M_EMPTY && card_present && card_multi_detect)
    |=> code_out == `CODE_MULTI_DETECT)
    else $error("detect did not drive 011");
  a_multi_power: assert property (@(posedge mclk) disable iff (rst) // see RULE_12
    (state_r == card_power_pkg::ST_M_DETECT && card_present && id_done && id_is_multi)
    |=> code_out == `CODE_MULTI_PWR)
    else $error("multi card not at 100");
  a_single_switch: assert property (@(posedge mclk) disable iff (rst) // see RULE_13
    (state_r == card_power_pkg::ST_M_DETECT && card_present && id_done && !id_is_multi && single_ok)
    |=> single_mode && code_out == `CODE_ALL_3V3)
    else $error("single card not repowered");
  a_refused_idle: assert property (@(posedge mclk) disable iff (rst) // see RULE_14
    (state_r == card_power_pkg::ST_M_REFUSED && card_present) |=> code_out == `CODE_ALL_HIZ)
    else $error("refused card powered");
  a_m_removal: assert property (@(posedge mclk) disable iff (rst) // see RULE_15
    (state_r == card_power_pkg::ST_M_POWERED && removal) |=> code_out == `CODE_ALL_GND)
    else $error("multi removal skipped 111");
  a_dischg_exit: assert property (@(posedge mclk) disable iff (rst) // see RULE_15
    (state_r == card_power_pkg::ST_M_DISCHG && dwell_done) |=> code_out == `CODE_ALL_HIZ)
    else $error("discharge did not return to 010");
  a_s_base_hold: assert property (@(posedge mclk) disable iff (rst) // see RULE_06
    (state_r == card_power_pkg::ST_S_BASE && !multi_host && !(card_info_request && grant_5v))
    |=> code_out == `CODE_ALL_3V3)
    else $error("single host left 000 without a granted request");
  a_gnd_dwell: assert property (@(posedge mclk) disable iff (rst) // see RULE_18
    ((state_r == card_power_pkg::ST_M_DISCHG || state_r == card_power_pkg::ST_M_PWRUP_GND) && !dwell_done)
    |=> code_out == `CODE_ALL_GND)
    else $error("111 dropped before dwell end");
  a_aux_dwell: assert property (@(posedge mclk) disable iff (rst) // see RULE_18
    (state_r == card_power_pkg::ST_S_DISCHG && !dwell_done) |=> code_out == `CODE_AUX_DISCHG)
    else $error("110 dropped before dwell end");
  a_dwell_bound: assert property (@(posedge mclk) disable iff (rst) // see RULE_18
    dwell_r <= `DWELL_W'(`DWELL_CYCLES - 1))
    else $error("dwell counter ran past its end");

  c_s_grant:   cover property (@(posedge mclk) disable iff (rst) state_r == card_power_pkg::ST_S_AUX5);
  c_s_direct:  cover property (@(posedge mclk) disable iff (rst) state_r == card_power_pkg::ST_S_AUX5 && removal && !discharge_en);
  c_m_power:   cover property (@(posedge mclk) disable iff (rst) state_r == card_power_pkg::ST_M_POWERED);
  c_m_single:  cover property (@(posedge mclk) disable iff (rst) multi_host && single_mode);
  c_m_dischg:  cover property (@(posedge mclk) disable iff (rst)
    state_r == card_power_pkg::ST_M_DISCHG ##1 state_r == card_power_pkg::ST_M_EMPTY);

endmodule

// >>> card_power_defs.svh
/*
  Control codes, timing figures and dwell counts for the card power sequencer.
  Assumes a 50 MHz system clock.
*/
`ifndef CARD_POWER_DEFS_SVH
`define CARD_POWER_DEFS_SVH

`define CODE_ALL_3V3      3'h0
`define CODE_AUX_5V       3'h1
`define CODE_ALL_HIZ      3'h2
`define CODE_MULTI_DETECT 3'h3
`define CODE_MULTI_PWR    3'h4
`define CODE_AUX2_GND     3'h5
`define CODE_AUX_DISCHG   3'h6
`define CODE_ALL_GND      3'h7

`define CLK_MHZ           50
`define DWELL_US          100
`define DWELL_CYCLES      (`DWELL_US * `CLK_MHZ)
`define DWELL_W           16

`endif

// >>> card_power_pkg.sv
/*
  Types of the card power sequencer.
  Assumes nothing beyond the defs header.
*/
package card_power_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_S_BASE,
    ST_S_AUX5,
    ST_S_DISCHG,
    ST_M_PWRUP_GND,
    ST_M_EMPTY,
    ST_M_DETECT,
    ST_M_POWERED,
    ST_M_REFUSED,
    ST_M_DISCHG
  } seq_state_e;
endpackage

// >>> card_dev_model.sv
/*
  Behavioural model of the card power switch driven by the sequencer.
  Assumes code pins settle between mclk edges; rails coded 0 Hi-Z, 1 GND, 2 3.3V, 3 5V.
*/
`timescale 1ns/1ps
module card_dev_model #(
  parameter int OC_CYCLES = 20
) (
  // Clock
  input  wire logic       mclk,
  // Control code and supply state
  input  wire logic       ctrl_sel_bit0,
  input  wire logic       ctrl_sel_bit1,
  input  wire logic       ctrl_sel_bit2,
  input  wire logic       low_supply_ok,
  // Fault causes
  input  wire logic       over_current,
  input  wire logic       over_temp,
  // Outputs {main, aux1, aux2} and fault flag
  output logic [5:0]      rails,
  output logic            fault_n
);
  logic [31:0] oc_cnt_r;
  logic [5:0]  decoded;

  always_comb begin
    case ({ctrl_sel_bit2, ctrl_sel_bit1, ctrl_sel_bit0})
      3'h0: decoded = 6'h2A;
      3'h1: decoded = 6'h2F;
      3'h2: decoded = 6'h00;
      3'h3: decoded = 6'h04;
      3'h4: decoded = 6'h27;
      3'h5: decoded = 6'h2D;
      3'h6: decoded = 6'h25;
      default: decoded = 6'h15;
    endcase
  end

  // Lockout wins over any code
  assign rails = low_supply_ok ? decoded : 6'h00;

  // Short spikes filtered, heat reported at once
  always_ff @(posedge mclk) begin
    oc_cnt_r <= over_current ? oc_cnt_r + 32'h1 : 32'h0;
  end
  assign fault_n = !(over_temp || oc_cnt_r >= OC_CYCLES);
endmodule

// >>> tb.sv
/*
  Self-checking bench for the card power sequencer.
  Assumes the defs header and the switch model beside it.
*/
`timescale 1ns/1ps
`include "card_power_defs.svh"
module tb;
  localparam int OC = 20;
  logic       mclk, rst, multi_host, discharge_en, accept_single, grant_5v;
  logic       card_present, card_multi_detect, id_done, id_is_multi, channel_one_support;
  logic       card_info_request, over_current, over_temp, fault_n, single_mode, card_fault, low_ok;
  wire  [2:0] code;
  logic [5:0] rails;
  int         n_fail, checks_done, cycles;

  card_power_seq i_dut (.mclk(mclk), .rst(rst), .multi_host(multi_host), .discharge_en(discharge_en),
    .accept_single(accept_single), .grant_5v(grant_5v), .card_present(card_present),
    .card_multi_detect(card_multi_detect), .id_done(id_done), .id_is_multi(id_is_multi),
    .channel_one_support(channel_one_support), .card_info_request(card_info_request), .fault_n(fault_n),
    .ctrl_sel_bit0(code[0]), .ctrl_sel_bit1(code[1]), .ctrl_sel_bit2(code[2]),
    .single_mode(single_mode), .card_fault(card_fault));
  card_dev_model #(.OC_CYCLES(OC)) i_dev (.mclk(mclk), .ctrl_sel_bit0(code[0]), .ctrl_sel_bit1(code[1]),
    .ctrl_sel_bit2(code[2]), .low_supply_ok(low_ok), .over_current(over_current), .over_temp(over_temp),
    .rails(rails), .fault_n(fault_n));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_code(input logic [2:0] exp, input int lim);
    for (int i = 0; i < lim && code !== exp; i++) tick(1);
  endtask
  task automatic start(input logic mh, input logic dis);
    rst = 1'b1; multi_host = mh; discharge_en = dis; accept_single = 1'b0; grant_5v = 1'b0;
    card_present = 1'b0; card_multi_detect = 1'b0; id_done = 1'b0; id_is_multi = 1'b0;
    channel_one_support = 1'b0; card_info_request = 1'b0; over_current = 1'b0; over_temp = 1'b0;
    low_ok = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(3);
  endtask
  task automatic ident(input logic multi, input logic ch1);
    card_present = 1'b1; card_multi_detect = 1'b1;
    wait_code(3'h3, 12);
    check(code, 3'h3);
    id_done = 1'b1; id_is_multi = multi; channel_one_support = ch1;
    tick(1);
    id_done = 1'b0;
  endtask
  task automatic remove_multi();
    card_present = 1'b0; card_multi_detect = 1'b0;
    wait_code(3'h7, 12);
    check(code, 3'h7);
    tick(`DWELL_CYCLES - 20);
    check(code, 3'h7);
    wait_code(3'h2, 40);
    check(code, 3'h2);
  endtask

  task automatic t_single();
    start(1'b0, 1'b1);
    check(code, 3'h0);
    card_present = 1'b1; card_info_request = 1'b1;
    tick(1);
    card_info_request = 1'b0; card_present = 1'b0;
    tick(5);
    check(code, 3'h0);
    card_present = 1'b1; grant_5v = 1'b1; card_info_request = 1'b1;
    tick(1);
    card_info_request = 1'b0;
    wait_code(3'h1, 12);
    tick(6);
    check(code, 3'h1);
    card_present = 1'b0;
    wait_code(3'h6, 12);
    check(code, 3'h6);
    tick(`DWELL_CYCLES - 20);
    check(code, 3'h6);
    wait_code(3'h0, 40);
    check(code, 3'h0);
  endtask

  // Single host without the optional 110 step
  task automatic t_single_direct();
    start(1'b0, 1'b0);
    card_present = 1'b1; grant_5v = 1'b1; card_info_request = 1'b1;
    tick(1);
    card_info_request = 1'b0;
    check(code, 3'h1);
    check(rails, 6'h2F);
    card_present = 1'b0;
    tick(1);
    check(code, 3'h0);
    check(rails, 6'h2A);
  endtask

  task automatic t_multi();
    start(1'b1, 1'b0);
    check(code, 3'h2);
    tick(6);
    check(code, 3'h2);
    ident(1'b1, 1'b0);
    wait_code(3'h4, 12);
    tick(6);
    check(code, 3'h4);
    check(rails, 6'h27);
    low_ok = 1'b0;
    tick(1);
    check(rails, 6'h00);
    low_ok = 1'b1;
    over_temp = 1'b1;
    tick(2);
    check({2'b00, card_fault}, 3'h1);
    over_temp = 1'b0; over_current = 1'b1;
    tick(OC - 2);
    check({2'b00, card_fault}, 3'h0);
    tick(4);
    check({2'b00, card_fault}, 3'h1);
    over_current = 1'b0;
    remove_multi();
  endtask

  task automatic t_single_card();
    start(1'b1, 1'b1);
    wait_code(3'h7, 12);
    check(code, 3'h7);
    wait_code(3'h2, `DWELL_CYCLES + 20);
    check(code, 3'h2);
    accept_single = 1'b1;
    ident(1'b0, 1'b1);
    wait_code(3'h0, 12);
    check(code, 3'h0);
    check({2'b00, single_mode}, 3'h1);
    remove_multi();
  endtask

  // Declined single card, then unsupported single card
  task automatic t_refused();
    for (int i = 0; i < 2; i++) begin
      start(1'b1, 1'b0);
      accept_single = (i == 1);
      ident(1'b0, i == 0);
      tick(8);
      check(code, 3'h2);
      check({2'b00, single_mode}, 3'h0);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    n_fail = 0; checks_done = 0; cycles = 0;
    t_single();
    t_single_direct();
    t_multi();
    t_single_card();
    t_refused();
    conclude();
  end
endmodule
